/* File: clock_divider_osc_fault_pkg.sv */
package clock_divider_osc_fault_pkg;

   // ****************************************************************
   // bus geometry
   // ****************************************************************
   localparam int REG_W = 16;
   localparam int ADDR_W = 5;

   // ****************************************************************
   // register offsets (byte addresses)
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_DIV_CTRL = 5'h0a;
   localparam logic [ADDR_W-1:0] OFS_OSC_CTRL = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_FAULT = 5'h0e;
   localparam logic [ADDR_W-1:0] OFS_REQ_EN = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h12;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h14;

   // ****************************************************************
   // reset values and writable masks
   // ****************************************************************
   localparam logic [REG_W-1:0] RST_DIV_CTRL = 16'h0000;
   localparam logic [REG_W-1:0] RST_OSC_CTRL = 16'hc1cd;
   localparam logic [REG_W-1:0] RST_FAULT_KEEP = 16'h0c00;
   localparam logic [REG_W-1:0] RST_REQ_EN = 16'h0707;
   localparam logic [REG_W-1:0] RST_IRQ_MASK = 16'h0000;
   localparam logic [REG_W-1:0] WMASK_DIV = 16'h7777;
   localparam logic [REG_W-1:0] WMASK_OSC = 16'hd1ff;
   localparam logic [REG_W-1:0] WMASK_FAULT_KEEP = 16'h3c10;
   localparam logic [REG_W-1:0] FAULT_RO_ONES = 16'h0300;
   localparam logic [REG_W-1:0] WMASK_REQ = 16'h071f;

   // ****************************************************************
   // fault flag positions
   // ****************************************************************
   localparam int NUM_FAULTS = 4;
   localparam int FLT_DCO = 0;
   localparam int FLT_A_LF = 1;
   localparam int FLT_A_HF = 2;
   localparam int FLT_B = 3;
   localparam logic [NUM_FAULTS-1:0] RST_FAULT_FLAGS = 4'h3;

   // ****************************************************************
   // request enable positions
   // ****************************************************************
   localparam int NUM_REQ = 4;
   localparam int REQ_AUX = 0;
   localparam int REQ_MASTER = 1;
   localparam int REQ_SUBSYS = 2;
   localparam int REQ_MODULE_OSCILLATOR = 3;

   // ****************************************************************
   // divider and tap constants
   // ****************************************************************
   localparam int DIV_CODE_W = 3;
   localparam int DIV_MAX_SHIFT = 5;
   localparam int TAP_W = 5;
   localparam logic [TAP_W-1:0] TAP_MIN = 5'h00;
   localparam logic [TAP_W-1:0] TAP_MAX = 5'h1f;

   // ****************************************************************
   // register layouts and bus carrier
   // ****************************************************************
   typedef struct packed {
      logic rsv15;
      logic [2:0] pin_aux_divider;
      logic rsv11;
      logic [2:0] aux_divider;
      logic rsv7;
      logic [2:0] subsys_divider;
      logic rsv3;
      logic [2:0] master_divider;
   } div_ctrl_t;

   typedef struct packed {
      logic [1:0] osc_b_drive;
      logic rsv13;
      logic osc_b_bypass;
      logic [2:0] rsv11_9;
      logic osc_b_disable;
      logic [1:0] osc_a_drive;
      logic osc_a_freq_mode;
      logic osc_a_bypass;
      logic [1:0] osc_a_load_cap;
      logic subsys_clock_gate;
      logic osc_a_disable;
   } osc_ctrl_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0] wdata;
   } reg_req_t;

endpackage : clock_divider_osc_fault_pkg

/* File: pow2_tick_divider.sv */
`timescale 1ns/10ps
module pow2_tick_divider #(
   parameter int MAX_SHIFT = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // divide code and ticks
   input wire logic [2:0] code,
   input wire logic in_tick,
   output logic out_tick
);

   // refuse a top step of zero or one above what the 3-bit shift can hold
   if (MAX_SHIFT < 1 || MAX_SHIFT > 7) begin : g_bad_shift
      $error("pow2_tick_divider: MAX_SHIFT out of range");
   end

   logic [2:0] code_q;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [2:0] shift;
   logic [7:0] term;
   logic at_term;
   logic tick_q;

   // codes above the top step hold at the top ratio
   assign shift = (code_q > 3'(MAX_SHIFT)) ? 3'(MAX_SHIFT) : code_q;
   assign term = 8'((9'd1 << shift) - 9'd1);
   assign at_term = (cnt_q == term);
   assign cnt_d = at_term ? 8'h00 : 8'(cnt_q + 8'h01);

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= 8'h00;
         code_q <= 3'h0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= in_tick & at_term;
         if (in_tick) begin
            cnt_q <= cnt_d;
         end
         if (in_tick && at_term) begin
            code_q <= code;
         end
      end
   end

   assign out_tick = tick_q;

endmodule : pow2_tick_divider

/* File: sticky_flag.sv */
`timescale 1ns/10ps
module sticky_flag #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // set and clear
   input wire logic set,
   input wire logic clear,
   output logic flag
);

   logic flag_q;
   logic flag_d;

   // set wins over a clear in the same cycle
   assign flag_d = set | (flag_q & ~clear);

   always_ff @(posedge clk) begin
      if (reset) begin
         flag_q <= RESET_VAL;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;

endmodule : sticky_flag

/* File: clock_divider_osc_fault_ctrl.sv */
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
module clock_divider_osc_fault_ctrl
   import clock_divider_osc_fault_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire reg_req_t reg_req,
   output logic [REG_W-1:0] rdata,
   // source clock ticks
   input wire logic aux_src_tick,
   input wire logic subsys_src_tick,
   input wire logic master_src_tick,
   // divided clock ticks
   output logic aux_clk_tick,
   output logic subsys_clk_tick,
   output logic master_clk_tick,
   output logic aux_pin_tick,
   // oscillator pin selection and usage
   input wire logic osc_a_pin_sel,
   input wire logic osc_b_pin_sel,
   input wire logic osc_a_in_use,
   input wire logic osc_b_in_use,
   // oscillator controls
   output logic osc_a_run,
   output logic osc_b_run,
   output logic osc_a_high_freq,
   output logic [1:0] osc_a_cap_sel,
   output logic [1:0] osc_a_drive,
   output logic [1:0] osc_b_drive,
   output logic osc_a_bypass,
   output logic osc_b_bypass,
   // fault conditions
   input wire logic osc_a_fault,
   input wire logic osc_b_fault,
   input wire logic [TAP_W-1:0] dco_tap,
   // conditional module requests
   input wire logic [NUM_REQ-1:0] module_req,
   output logic [NUM_REQ-1:0] clk_req_grant,
   // interrupts
   output logic combined_osc_fault_irq,
   output logic irq
);

   // ****************************************************************
   // register storage
   // ****************************************************************
   logic [REG_W-1:0] div_ctrl_q;
   logic [REG_W-1:0] osc_ctrl_q;
   logic [REG_W-1:0] fault_keep_q;
   logic [REG_W-1:0] req_en_q;
   logic [REG_W-1:0] irq_mask_q;
   logic [REG_W-1:0] rdata_q;

   div_ctrl_t div_f;
   osc_ctrl_t osc_f;

   assign div_f = div_ctrl_q;
   assign osc_f = osc_ctrl_q;

   // ****************************************************************
   // address decode
   // ****************************************************************
   logic hit_div;
   logic hit_osc;
   logic hit_fault;
   logic hit_req;
   logic hit_status;
   logic hit_mask;
   logic wr_div;
   logic wr_osc;
   logic wr_fault;
   logic wr_req;
   logic wr_status;
   logic wr_mask;

   assign hit_div = (reg_req.addr == OFS_DIV_CTRL);
   assign hit_osc = (reg_req.addr == OFS_OSC_CTRL);
   assign hit_fault = (reg_req.addr == OFS_FAULT);
   assign hit_req = (reg_req.addr == OFS_REQ_EN);
   assign hit_status = (reg_req.addr == OFS_IRQ_STATUS);
   assign hit_mask = (reg_req.addr == OFS_IRQ_MASK);
   assign wr_div = reg_req.wr & hit_div;
   assign wr_osc = reg_req.wr & hit_osc;
   assign wr_fault = reg_req.wr & hit_fault;
   assign wr_req = reg_req.wr & hit_req;
   assign wr_status = reg_req.wr & hit_status;
   assign wr_mask = reg_req.wr & hit_mask;

   // ****************************************************************
   // control register writes
   // ****************************************************************
   logic [REG_W-1:0] div_ctrl_d;
   logic [REG_W-1:0] osc_ctrl_d;
   logic [REG_W-1:0] fault_keep_d;
   logic [REG_W-1:0] req_en_d;
   logic [REG_W-1:0] irq_mask_d;

   assign div_ctrl_d = wr_div ? (reg_req.wdata & WMASK_DIV) : div_ctrl_q;
   assign osc_ctrl_d = wr_osc ? (reg_req.wdata & WMASK_OSC) : osc_ctrl_q;
   assign fault_keep_d = wr_fault ? (reg_req.wdata & WMASK_FAULT_KEEP)
                                  : fault_keep_q;
   assign req_en_d = wr_req ? (reg_req.wdata & WMASK_REQ) : req_en_q;
   assign irq_mask_d = wr_mask ? reg_req.wdata : irq_mask_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         div_ctrl_q <= RST_DIV_CTRL;
         osc_ctrl_q <= RST_OSC_CTRL;
         fault_keep_q <= RST_FAULT_KEEP;
         req_en_q <= RST_REQ_EN;
         irq_mask_q <= RST_IRQ_MASK;
      end else begin
         div_ctrl_q <= div_ctrl_d;
         osc_ctrl_q <= osc_ctrl_d;
         fault_keep_q <= fault_keep_d;
         req_en_q <= req_en_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   // ****************************************************************
   // clock dividers
   // ****************************************************************
   logic aux_div_tick;
   logic subsys_div_tick;
   logic subsys_src_gated;

   assign subsys_src_gated = subsys_src_tick & ~osc_f.subsys_clock_gate;

   pow2_tick_divider #(
      .MAX_SHIFT(DIV_MAX_SHIFT)
   ) u_aux_div (
      .clk(clk),
      .reset(reset),
      .code(div_f.aux_divider),
      .in_tick(aux_src_tick),
      .out_tick(aux_div_tick)
   );

   pow2_tick_divider #(
      .MAX_SHIFT(DIV_MAX_SHIFT)
   ) u_subsys_div (
      .clk(clk),
      .reset(reset),
      .code(div_f.subsys_divider),
      .in_tick(subsys_src_gated),
      .out_tick(subsys_div_tick)
   );

   pow2_tick_divider #(
      .MAX_SHIFT(DIV_MAX_SHIFT)
   ) u_master_div (
      .clk(clk),
      .reset(reset),
      .code(div_f.master_divider),
      .in_tick(master_src_tick),
      .out_tick(master_clk_tick)
   );

   pow2_tick_divider #(
      .MAX_SHIFT(DIV_MAX_SHIFT)
   ) u_pin_div (
      .clk(clk),
      .reset(reset),
      .code(div_f.pin_aux_divider),
      .in_tick(aux_div_tick),
      .out_tick(aux_pin_tick)
   );

   assign aux_clk_tick = aux_div_tick;
   assign subsys_clk_tick = subsys_div_tick & ~osc_f.subsys_clock_gate;

   // ****************************************************************
   // oscillator policy
   // ****************************************************************
   // first and second oscillator run
   assign osc_a_run = osc_a_pin_sel & ~osc_f.osc_a_bypass &
                      (~osc_f.osc_a_disable | osc_a_in_use);
   assign osc_b_run = osc_b_pin_sel & ~osc_f.osc_b_bypass &
                      (~osc_f.osc_b_disable | osc_b_in_use);
   assign osc_a_high_freq = osc_f.osc_a_freq_mode;
   assign osc_a_cap_sel = osc_f.osc_a_freq_mode ? 2'h0 : osc_f.osc_a_load_cap;
   assign osc_a_drive = osc_f.osc_a_drive;
   assign osc_b_drive = osc_f.osc_b_drive;
   assign osc_a_bypass = osc_f.osc_a_bypass;
   assign osc_b_bypass = osc_f.osc_b_bypass;

   // ****************************************************************
   // fault flags
   // ****************************************************************
   logic [NUM_FAULTS-1:0] fault_set;
   logic [NUM_FAULTS-1:0] fault_clr;
   logic [NUM_FAULTS-1:0] fault_flags;
   logic tap_at_edge;

   assign tap_at_edge = (dco_tap == TAP_MIN) | (dco_tap == TAP_MAX);
   assign fault_set[FLT_DCO] = tap_at_edge;
   assign fault_set[FLT_A_LF] = osc_a_fault & ~osc_f.osc_a_freq_mode;
   assign fault_set[FLT_A_HF] = osc_a_fault & osc_f.osc_a_freq_mode;
   assign fault_set[FLT_B] = osc_b_fault;
   // writing a zero clears a flag
   assign fault_clr = {NUM_FAULTS{wr_fault}} & ~reg_req.wdata[NUM_FAULTS-1:0];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_FAULTS; gi++) begin : g_fault
         sticky_flag #(
            .RESET_VAL(RST_FAULT_FLAGS[gi])
         ) u_flag (
            .clk(clk),
            .reset(reset),
            .set(fault_set[gi]),
            .clear(fault_clr[gi]),
            .flag(fault_flags[gi])
         );
      end
   endgenerate

   assign combined_osc_fault_irq = |fault_flags;

   // ****************************************************************
   // interrupt status and mask
   // ****************************************************************
   logic [NUM_FAULTS-1:0] irq_status;
   logic [NUM_FAULTS-1:0] status_clr;

   assign status_clr = {NUM_FAULTS{wr_status}} &
                       reg_req.wdata[NUM_FAULTS-1:0];

   generate
      for (gi = 0; gi < NUM_FAULTS; gi++) begin : g_status
         sticky_flag #(
            .RESET_VAL(1'b0)
         ) u_status (
            .clk(clk),
            .reset(reset),
            .set(fault_flags[gi]),
            .clear(status_clr[gi]),
            .flag(irq_status[gi])
         );
      end
   endgenerate

   assign irq = |(irq_status & irq_mask_q[NUM_FAULTS-1:0]);

   // ****************************************************************
   // conditional clock requests
   // ****************************************************************
   // enables mask requests
   assign clk_req_grant = module_req & req_en_q[NUM_REQ-1:0];

   // ****************************************************************
   // read back
   // ****************************************************************
   logic [REG_W-1:0] fault_rd;
   logic [REG_W-1:0] status_rd;
   logic [REG_W-1:0] rd_mux;

   assign fault_rd = fault_keep_q | FAULT_RO_ONES |
                     {{(REG_W-NUM_FAULTS){1'b0}}, fault_flags};
   assign status_rd = {{(REG_W-NUM_FAULTS){1'b0}}, irq_status};
   assign rd_mux = hit_div ? div_ctrl_q :
                   hit_osc ? osc_ctrl_q :
                   hit_fault ? fault_rd :
                   hit_req ? req_en_q :
                   hit_status ? status_rd :
                   hit_mask ? irq_mask_q :
                   16'h0000;

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= reg_req.rd ? rd_mux : 16'h0000;
      end
   end

   assign rdata = rdata_q;

endmodule : clock_divider_osc_fault_ctrl

/* File: clock_divider_osc_fault_ctrl_properties.sv */
`timescale 1ns/10ps
module clock_divider_osc_fault_ctrl_properties
   import clock_divider_osc_fault_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire reg_req_t reg_req,
   // divider ticks
   input wire logic aux_src_tick,
   input wire logic aux_clk_tick,
   input wire logic subsys_clk_tick,
   input wire logic aux_pin_tick,
   // oscillators
   input wire logic osc_a_pin_sel,
   input wire logic osc_b_pin_sel,
   input wire logic osc_a_in_use,
   input wire logic osc_b_in_use,
   input wire logic osc_a_run,
   input wire logic osc_b_run,
   input wire logic osc_a_high_freq,
   input wire logic [1:0] osc_a_cap_sel,
   input wire logic osc_a_bypass,
   input wire logic osc_b_bypass,
   // faults and requests
   input wire logic osc_a_fault,
   input wire logic osc_b_fault,
   input wire logic [TAP_W-1:0] dco_tap,
   input wire logic [NUM_REQ-1:0] module_req,
   input wire logic [NUM_REQ-1:0] clk_req_grant,
   input wire logic combined_osc_fault_irq
);
   // ****
   // shadow copies of the control bits
   // ****
   logic [REG_W-1:0] osc_q;
   logic [NUM_REQ-1:0] en_q;
   wire osc_hit = reg_req.wr && reg_req.addr == OFS_OSC_CTRL;
   wire en_hit = reg_req.wr && reg_req.addr == OFS_REQ_EN;
   always_ff @(posedge clk) begin
      if (reset) begin
         osc_q <= RST_OSC_CTRL;
         en_q <= RST_REQ_EN[NUM_REQ-1:0];
      end else begin
         if (osc_hit)
            osc_q <= reg_req.wdata;
         if (en_hit)
            en_q <= reg_req.wdata[NUM_REQ-1:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // ****
   // properties
   // ****
   property p_aux_div;
      aux_clk_tick |-> $past(aux_src_tick);
   endproperty
   a_aux_div: assert property (p_aux_div) else $error("aux tick no source");
   property p_pin_div;
      aux_pin_tick |-> $past(aux_clk_tick);
   endproperty
   a_pin_div: assert property (p_pin_div) else $error("pin tick no aux");
   property p_b_run;
      osc_b_run == (osc_b_pin_sel && !osc_b_bypass && (!osc_q[8] || osc_b_in_use));
   endproperty
   a_b_run: assert property (p_b_run) else $error("osc b run wrong");
   property p_a_run;
      osc_a_run == (osc_a_pin_sel && !osc_a_bypass && (!osc_q[0] || osc_a_in_use));
   endproperty
   a_a_run: assert property (p_a_run) else $error("osc a run wrong");
   property p_gate;
      osc_q[1] |-> !subsys_clk_tick;
   endproperty
   a_gate: assert property (p_gate) else $error("subsys tick while off");
   property p_cap;
      osc_a_high_freq |-> osc_a_cap_sel == 2'b00;
   endproperty
   a_cap: assert property (p_cap) else $error("cap used in high mode");
   property p_b_flt;
      osc_b_fault |=> combined_osc_fault_irq;
   endproperty
   a_b_flt: assert property (p_b_flt) else $error("osc b fault lost");
   property p_a_flt;
      osc_a_fault |=> combined_osc_fault_irq;
   endproperty
   a_a_flt: assert property (p_a_flt) else $error("osc a fault lost");
   property p_dco;
      (dco_tap == TAP_MIN || dco_tap == TAP_MAX) |=> combined_osc_fault_irq;
   endproperty
   a_dco: assert property (p_dco) else $error("tap fault lost");
   property p_grant;
      clk_req_grant == (module_req & en_q);
   endproperty
   a_grant: assert property (p_grant) else $error("grant wrong");
endmodule : clock_divider_osc_fault_ctrl_properties

bind clock_divider_osc_fault_ctrl clock_divider_osc_fault_ctrl_properties
   props_inst (.clk(clk), .reset(reset), .reg_req(reg_req),
   .aux_src_tick(aux_src_tick), .aux_clk_tick(aux_clk_tick),
   .subsys_clk_tick(subsys_clk_tick), .aux_pin_tick(aux_pin_tick),
   .osc_a_pin_sel(osc_a_pin_sel), .osc_b_pin_sel(osc_b_pin_sel),
   .osc_a_in_use(osc_a_in_use), .osc_b_in_use(osc_b_in_use),
   .osc_a_run(osc_a_run), .osc_b_run(osc_b_run),
   .osc_a_high_freq(osc_a_high_freq), .osc_a_cap_sel(osc_a_cap_sel),
   .osc_a_bypass(osc_a_bypass), .osc_b_bypass(osc_b_bypass),
   .osc_a_fault(osc_a_fault), .osc_b_fault(osc_b_fault),
   .dco_tap(dco_tap), .module_req(module_req),
   .clk_req_grant(clk_req_grant),
   .combined_osc_fault_irq(combined_osc_fault_irq));

/* File: clock_divider_osc_fault_ctrl_test.sv */
`timescale 1ns/10ps
module clock_divider_osc_fault_ctrl_test import clock_divider_osc_fault_pkg::*;
   ;
   logic clk, reset, a_src, s_src, m_src, a_tk, s_tk, m_tk, p_tk;
   logic a_sel, b_sel, a_use, b_use, a_run, b_run, a_hf, a_byp, b_byp;
   logic a_flt, b_flt, comb, irq;
   logic [1:0] cap, a_drv, b_drv;
   logic [TAP_W-1:0] tap;
   logic [NUM_REQ-1:0] mreq, grant;
   logic [REG_W-1:0] rdata;
   reg_req_t reg_req;
   int err_total, compares, cm, ca, cs, cp;
   clock_divider_osc_fault_ctrl clock_divider_osc_fault_ctrl_inst (
      .clk(clk), .reset(reset), .reg_req(reg_req), .rdata(rdata),
      .aux_src_tick(a_src), .subsys_src_tick(s_src),
      .master_src_tick(m_src), .aux_clk_tick(a_tk), .subsys_clk_tick(s_tk),
      .master_clk_tick(m_tk), .aux_pin_tick(p_tk), .osc_a_pin_sel(a_sel),
      .osc_b_pin_sel(b_sel), .osc_a_in_use(a_use), .osc_b_in_use(b_use),
      .osc_a_run(a_run), .osc_b_run(b_run), .osc_a_high_freq(a_hf),
      .osc_a_cap_sel(cap), .osc_a_drive(a_drv), .osc_b_drive(b_drv),
      .osc_a_bypass(a_byp), .osc_b_bypass(b_byp), .osc_a_fault(a_flt),
      .osc_b_fault(b_flt), .dco_tap(tap), .module_req(mreq),
      .clk_req_grant(grant), .combined_osc_fault_irq(comb), .irq(irq));
   // ****
   // helpers
   // ****
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      reg_req <= '0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      reg_req <= '0;
      #1;
      check(rdata, exp);
   endtask : rd
   task automatic count_ticks(input int n);
      cm = 0;
      ca = 0;
      cs = 0;
      cp = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         cm += m_tk;
         ca += a_tk;
         cs += s_tk;
         cp += p_tk;
      end
   endtask : count_ticks
   task automatic tally_and_finish;
      $display("compares=%0d mismatches=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // ****
   // scenarios
   // ****
   task automatic t_reset;
      rd(OFS_DIV_CTRL, 16'h0000);
      rd(OFS_OSC_CTRL, 16'hc1cd);
      rd(OFS_FAULT, 16'h0f03);
      rd(OFS_REQ_EN, 16'h0707);
      rd(OFS_IRQ_STATUS, 16'h0003);
      rd(OFS_IRQ_MASK, 16'h0000);
      wr(5'h1e, 16'hffff);
      rd(5'h1e, 16'h0000);
      wr(OFS_DIV_CTRL, 16'hffff);
      rd(OFS_DIV_CTRL, 16'h7777);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_dividers;
      int d;
      @(posedge clk);
      {a_src, s_src, m_src} <= 3'b111;
      for (int c = 0; c < 8; c++) begin
         d = 64 >> ((c > 5) ? 5 : c);
         wr(OFS_DIV_CTRL, {5'h00, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]});
         count_ticks(40);
         count_ticks(64);
         check(16'(cm), 16'(d));
         check(16'(ca), 16'(d));
         check(16'(cs), 16'(d));
         wr(OFS_DIV_CTRL, {1'b0, c[2:0], 12'h000});
         count_ticks(40);
         count_ticks(64);
         check(16'(cp), 16'(d));
      end
      wr(OFS_OSC_CTRL, 16'hc1cf);
      count_ticks(40);
      check(16'(cs), 16'h0000);
      check(16'(cm), 16'h0028);
      wr(OFS_OSC_CTRL, 16'hc1cd);
      count_ticks(4);
      count_ticks(40);
      check(16'(cs), 16'h0028);
      wr(OFS_DIV_CTRL, 16'h0005);
      for (int w = 0; w < 100; w++) begin
         @(posedge clk);
         #1;
         if (m_tk) break;
      end
      check(m_tk, 1'b1);
      wr(OFS_DIV_CTRL, 16'h0000);
      count_ticks(20);
      check(16'(cm), 16'h0000);
      @(posedge clk);
      {a_src, s_src, m_src} <= 3'b000;
      $display("t_dividers done");
   endtask : t_dividers
   task automatic t_osc;
      logic [3:0] a, b;
      for (int i = 0; i < 16; i++) begin
         a = i[3:0];
         b = a ^ 4'h6;
         wr(OFS_OSC_CTRL, 16'hc0cc | {3'h0, b[3], 3'h0, b[0], 3'h0, a[3],
            3'h0, a[0]});
         {a_sel, a_use, b_sel, b_use} <= {a[1], a[2], b[1], b[2]};
         @(posedge clk);
         #1;
         check(a_run, a[1] & ~a[3] & (~a[0] | a[2]));
         check(b_run, b[1] & ~b[3] & (~b[0] | b[2]));
         check({a_byp, b_byp}, {a[3], b[3]});
      end
      wr(OFS_OSC_CTRL, 16'hc0ec);
      #1;
      check({a_hf, cap}, 3'b100);
      wr(OFS_OSC_CTRL, 16'hc0cc);
      #1;
      check({a_hf, cap, a_drv, b_drv}, 7'h3f);
      $display("t_osc done");
   endtask : t_osc
   task automatic fault_case(input logic [4:0] t, input logic a, b, h,
      input int k);
      logic [15:0] f;
      f = 16'h0001 << k;
      wr(OFS_OSC_CTRL, h ? 16'hc1ed : 16'hc1cd);
      @(posedge clk);
      {tap, a_flt, b_flt} <= {t, a, b};
      repeat (2) @(posedge clk);
      wr(OFS_FAULT, 16'h0c00);
      rd(OFS_FAULT, 16'h0f00 | f);
      @(posedge clk);
      {tap, a_flt, b_flt} <= {5'h10, 2'b00};
      rd(OFS_FAULT, 16'h0f00 | f);
      rd(OFS_IRQ_STATUS, f);
      check({irq, comb}, 2'b01);
      wr(OFS_IRQ_MASK, f);
      #1;
      check(irq, 1'b1);
      wr(OFS_FAULT, 16'h0c00);
      wr(OFS_IRQ_STATUS, f);
      rd(OFS_IRQ_STATUS, 16'h0000);
      check({irq, comb}, 2'b00);
      wr(OFS_IRQ_MASK, 16'h0000);
   endtask : fault_case
   task automatic t_faults;
      wr(OFS_FAULT, 16'h0c00);
      wr(OFS_IRQ_STATUS, 16'h000f);
      rd(OFS_FAULT, 16'h0f00);
      fault_case(5'h00, 1'b0, 1'b0, 1'b0, 0);
      fault_case(5'h1f, 1'b0, 1'b0, 1'b0, 0);
      fault_case(5'h10, 1'b1, 1'b0, 1'b0, 1);
      fault_case(5'h10, 1'b1, 1'b0, 1'b1, 2);
      fault_case(5'h10, 1'b0, 1'b1, 1'b0, 3);
      $display("t_faults done");
   endtask : t_faults
   task automatic t_req;
      for (int e = 0; e < 16; e++) begin
         wr(OFS_REQ_EN, {5'h00, 3'h7, 4'h0, e[3:0]});
         mreq <= 4'hd ^ e[3:0];
         rd(OFS_REQ_EN, {5'h00, 3'h7, 4'h0, e[3:0]});
         check(grant, (4'hd ^ e[3:0]) & e[3:0]);
      end
      $display("t_req done");
   endtask : t_req
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      {reset, a_src, s_src, m_src, a_sel, b_sel, a_use, b_use} = 8'h80;
      {a_flt, b_flt, mreq, tap} = {2'b00, 4'h0, 5'h10};
      reg_req = '0;
      err_total = 0;
      compares = 0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_dividers();
      t_osc();
      t_faults();
      t_req();
      tally_and_finish();
   end
endmodule : clock_divider_osc_fault_ctrl_test
